// file: inc/tdc_pkg.sv
// Shared constants and carriers for the tone dialer disable/output control.
// Assumes a single 40 MHz core clock and a synchronous active-high reset.
`default_nettype none
package tdc_pkg;
  localparam int NUM_ROWS = 4;
  localparam int NUM_COLS = 4;
  localparam int REF_DIV = 2;
  localparam logic [7:0] LOW_GROUP_FREQ_HZ [4] = '{8'h00, 8'h00, 8'h00, 8'h00};

  typedef enum logic [1:0] {
    TDC_IDLE = 2'b00,
    TDC_SCAN = 2'b01,
    TDC_TONE = 2'b10
  } tdc_state_e;

  // Tone selection handed to the synthesis stage
  typedef struct packed {
    logic low_en;
    logic high_en;
    logic [1:0] row_sel;
    logic [1:0] col_sel;
  } tdc_tone_s;
endpackage : tdc_pkg
`default_nettype wire

// file: src/tdc_key_decode.sv
// Key matrix decoder: turns row and column levels into a tone selection.
// Assumes rows and columns are already synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module tdc_key_decode #(
  parameter int ROWS = tdc_pkg::NUM_ROWS,
  parameter int COLS = tdc_pkg::NUM_COLS
) (
  input wire logic [ROWS-1:0] rows_in,
  input wire logic [COLS-1:0] cols_in,
  input wire logic single_permit_in,
  output var tdc_pkg::tdc_tone_s tone_out
);
  logic [2:0] row_cnt;
  logic [2:0] col_cnt;
  logic [1:0] row_idx;
  logic [1:0] col_idx;

  always_comb begin
    row_cnt = 3'h0;
    col_cnt = 3'h0;
    row_idx = 2'h0;
    col_idx = 2'h0;
    for (int i = 0; i < ROWS; i++) begin
      if (rows_in[i]) begin
        row_cnt = row_cnt + 3'h1;
        row_idx = i[1:0];
      end
    end
    for (int j = 0; j < COLS; j++) begin
      if (cols_in[j]) begin
        col_cnt = col_cnt + 3'h1;
        col_idx = j[1:0];
      end
    end
  end

  always_comb begin
    tone_out = '0;
    tone_out.row_sel = row_idx;
    tone_out.col_sel = col_idx;
    if (row_cnt == 3'h1 && col_cnt == 3'h1) begin
      tone_out.low_en = 1'b1; // R12
      tone_out.high_en = 1'b1; // R12
    end else if (row_cnt == 3'h1 && col_cnt != 3'h1) begin
      // Lone row or two keys in one row
      tone_out.low_en = single_permit_in; // R13
    end else if (row_cnt == 3'h2 && col_cnt == 3'h1) begin
      tone_out.high_en = single_permit_in; // R13
    end
    // Anything else, e.g. two keys sharing nothing, stays silent
  end
endmodule : tdc_key_decode
`default_nettype wire

// file: src/tdc_control.sv
// Disable and output control of a keypad tone generator.
// Assumes keypad levels are synchronous to CORE_CLK_IN; pads resolve enables.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R01: Disable input is active high.
// R02: Disabled: tone output held low.
// R03: Disabled: keypad pins released, pulls off.
// R04: Disabled: oscillator stopped, no scanning.
// R05: Disabled device looks disconnected from keypad.
// R06: Disable input has internal pull-down.
// R07: No key: mute low, line drive active.
// R08: Key held: mute high, line drive released.
// R09: Disabled: mute low, line drive active.
// R10: High row signals closure, starts scan.
// R11: Oscillator runs only with row; ref/2.
// R12: Row plus column gives dual tone.
// R13: Lone row or shared line: single tone.
// R14: Disabling clears key and scan state.
module tdc_control (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic DEVICE_DISABLE_IN,
  input wire logic SINGLE_TONE_PERMIT_IN,
  input wire logic [tdc_pkg::NUM_ROWS-1:0] ROW_IN,
  input wire logic [tdc_pkg::NUM_COLS-1:0] COL_IN,
  output logic [tdc_pkg::NUM_ROWS-1:0] ROW_PULLDOWN_EN_OUT,
  output logic [tdc_pkg::NUM_COLS-1:0] COL_PULLUP_EN_OUT,
  output logic DISABLE_PULLDOWN_EN_OUT,
  output logic OSC_RUN_OUT,
  output logic REF_HALF_OUT,
  output logic TONE_ACTIVE_OUT,
  output var tdc_pkg::tdc_tone_s TONE_SEL_OUT,
  output logic MUTE_OUT,
  output logic LINE_DRIVE_OUT,
  output logic LINE_DRIVE_OE_N_OUT
);
  tdc_pkg::tdc_state_e state;
  tdc_pkg::tdc_state_e next_state;
  logic ref_half;
  logic next_ref_half;
  tdc_pkg::tdc_tone_s tone;
  tdc_pkg::tdc_tone_s next_tone;
  logic mute;
  logic next_mute;
  tdc_pkg::tdc_tone_s decoded;
  logic any_row;
  logic disabled;

  // ********************************************
  // Key detection and decode
  // ********************************************
  assign disabled = DEVICE_DISABLE_IN; // R01
  assign any_row = |ROW_IN; // R10

  tdc_key_decode #(
    .ROWS(tdc_pkg::NUM_ROWS),
    .COLS(tdc_pkg::NUM_COLS)
  ) u_decode (
    .rows_in(ROW_IN),
    .cols_in(COL_IN),
    .single_permit_in(SINGLE_TONE_PERMIT_IN),
    .tone_out(decoded)
  );

  // ********************************************
  // Scan state, reference divider, outputs
  // ********************************************
  always_comb begin
    next_state = state;
    next_ref_half = ref_half;
    next_tone = tone;
    next_mute = mute;
    if (disabled) begin
      // Drop everything so re-enable starts from idle
      next_state = tdc_pkg::TDC_IDLE; // R14
      next_ref_half = 1'b0; // R04
      next_tone = '0; // R02
      next_mute = 1'b0; // R09
    end else begin
      unique case (state)
        tdc_pkg::TDC_IDLE: begin
          next_tone = '0;
          next_mute = 1'b0; // R07
          if (any_row) begin
            next_state = tdc_pkg::TDC_SCAN; // R10
          end
        end
        tdc_pkg::TDC_SCAN: begin
          next_ref_half = ~ref_half; // R11
          // A row gone before the scan ends must not leave a mute pulse
          next_mute = any_row; // R07 R08
          next_tone = decoded;
          next_state = any_row ? tdc_pkg::TDC_TONE : tdc_pkg::TDC_IDLE;
        end
        tdc_pkg::TDC_TONE: begin
          next_ref_half = ~ref_half; // R11
          next_tone = decoded; // R12 R13
          next_mute = any_row; // R08
          if (!any_row) begin
            next_state = tdc_pkg::TDC_IDLE;
            next_tone = '0;
            next_ref_half = 1'b0;
          end
        end
        default: begin
          next_state = tdc_pkg::TDC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      state <= tdc_pkg::TDC_IDLE;
      ref_half <= 1'b0;
      tone <= '0;
      mute <= 1'b0;
    end else begin
      state <= next_state;
      ref_half <= next_ref_half;
      tone <= next_tone;
      mute <= next_mute;
    end
  end

  // ********************************************
  // Pin-facing outputs
  // ********************************************
  // Pulls gate off the moment disable is seen, not a cycle later
  assign ROW_PULLDOWN_EN_OUT = {tdc_pkg::NUM_ROWS{~disabled}}; // R03 R05
  assign COL_PULLUP_EN_OUT = {tdc_pkg::NUM_COLS{~disabled}}; // R03 R05
  assign DISABLE_PULLDOWN_EN_OUT = 1'b1; // R06
  assign OSC_RUN_OUT = (state != tdc_pkg::TDC_IDLE) && !disabled; // R04 R11
  assign REF_HALF_OUT = ref_half;
  assign TONE_SEL_OUT = tone;
  assign TONE_ACTIVE_OUT = (tone.low_en | tone.high_en) && !disabled; // R02
  assign MUTE_OUT = mute;
  assign LINE_DRIVE_OUT = 1'b1;
  assign LINE_DRIVE_OE_N_OUT = mute; // R07 R08 R09

  // ********************************************
  // Checks
  // ********************************************
  chk_disable_tone_low: assert property ( // R02
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    DEVICE_DISABLE_IN |-> !TONE_ACTIVE_OUT)
    else $error("tone active while disabled");
  chk_disable_pulls_off: assert property ( // R03
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    DEVICE_DISABLE_IN |-> (ROW_PULLDOWN_EN_OUT == '0 && COL_PULLUP_EN_OUT == '0))
    else $error("keypad pulls on while disabled");
  chk_disable_osc_stop: assert property ( // R04
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    DEVICE_DISABLE_IN |-> !OSC_RUN_OUT)
    else $error("oscillator runs while disabled");
  chk_disable_ref_stop: assert property ( // R04
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    DEVICE_DISABLE_IN |=> !REF_HALF_OUT)
    else $error("reference divider left running while disabled");
  chk_disable_mute_idle: assert property ( // R09
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    DEVICE_DISABLE_IN |=> (!MUTE_OUT && !LINE_DRIVE_OE_N_OUT))
    else $error("mute or line drive wrong after disable");
  chk_no_key_idle: assert property ( // R07
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (!DEVICE_DISABLE_IN && ROW_IN == '0)[*2] |-> (!MUTE_OUT && !LINE_DRIVE_OE_N_OUT))
    else $error("mute high with no key");
  chk_release_idle: assert property ( // R07
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (!DEVICE_DISABLE_IN && state != tdc_pkg::TDC_IDLE && ROW_IN == '0)
    |=> (!MUTE_OUT && !OSC_RUN_OUT && !TONE_SEL_OUT.low_en && !TONE_SEL_OUT.high_en))
    else $error("key release did not return to idle");
  chk_key_mutes: assert property ( // R08
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (!DEVICE_DISABLE_IN && ROW_IN != '0)[*3] |-> (MUTE_OUT && LINE_DRIVE_OE_N_OUT))
    else $error("key held but not muted");
  chk_row_starts_scan: assert property ( // R10
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (!DEVICE_DISABLE_IN && ROW_IN != '0)[*2] |-> OSC_RUN_OUT)
    else $error("row active but oscillator idle");
  chk_ref_halves: assert property ( // R11
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (OSC_RUN_OUT && $past(OSC_RUN_OUT) && state == tdc_pkg::TDC_TONE && any_row)
    |=> (REF_HALF_OUT != $past(REF_HALF_OUT)))
    else $error("reference not halved");
  chk_osc_needs_row: assert property ( // R11
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    ROW_IN == '0 |=> !OSC_RUN_OUT)
    else $error("oscillator runs with no row active");
  chk_reenable_idle: assert property ( // R14
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    DEVICE_DISABLE_IN |=> (state == tdc_pkg::TDC_IDLE && TONE_SEL_OUT == '0))
    else $error("state kept across disable");

  // ********************************************
  // Tone selection checks
  // ********************************************
  // Antecedents wait for the tone state so a fresh key is not judged early
  chk_dual_tone: assert property ( // R12
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (state == tdc_pkg::TDC_TONE && !DEVICE_DISABLE_IN && any_row && $onehot(ROW_IN)
    && $onehot(COL_IN)) |=> (TONE_SEL_OUT.low_en && TONE_SEL_OUT.high_en))
    else $error("dual tone missing");
  chk_dual_index: assert property ( // R12
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (state == tdc_pkg::TDC_TONE && !DEVICE_DISABLE_IN && $onehot(ROW_IN)
    && $onehot(COL_IN))
    |=> ($past(ROW_IN) == (4'h1 << TONE_SEL_OUT.row_sel)
    && $past(COL_IN) == (4'h1 << TONE_SEL_OUT.col_sel)))
    else $error("dual tone selects wrong row or column");
  chk_split_keys_silent: assert property ( // R12
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (state == tdc_pkg::TDC_TONE && !DEVICE_DISABLE_IN
    && $countones(ROW_IN) == 2 && $countones(COL_IN) == 2)
    |=> (!TONE_SEL_OUT.low_en && !TONE_SEL_OUT.high_en))
    else $error("keys sharing no line gave a tone");
  chk_lone_row_low: assert property ( // R13
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (state == tdc_pkg::TDC_TONE && !DEVICE_DISABLE_IN && SINGLE_TONE_PERMIT_IN
    && $onehot(ROW_IN) && COL_IN == '0)
    |=> (TONE_SEL_OUT.low_en && !TONE_SEL_OUT.high_en))
    else $error("lone row gave no low tone");
  chk_shared_col_high: assert property ( // R13
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (state == tdc_pkg::TDC_TONE && !DEVICE_DISABLE_IN && SINGLE_TONE_PERMIT_IN
    && $countones(ROW_IN) == 2 && $onehot(COL_IN))
    |=> (TONE_SEL_OUT.high_en && !TONE_SEL_OUT.low_en))
    else $error("two keys in one column gave no high tone");
  // Without the permit only a clean dual key may sound
  chk_permit_blocks: assert property ( // R13
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (state == tdc_pkg::TDC_TONE && !DEVICE_DISABLE_IN && !SINGLE_TONE_PERMIT_IN
    && !($onehot(ROW_IN) && $onehot(COL_IN)))
    |=> (!TONE_SEL_OUT.low_en && !TONE_SEL_OUT.high_en))
    else $error("single tone sounded without permit");
endmodule : tdc_control
`default_nettype wire

// file: tb/tdc_keypad_model.sv
// Keypad far side: closed keys tie rows to columns, driven high.
// Assumes the device pulls idle lines low; released lines float.
`timescale 1ns/10ps
`default_nettype none
module tdc_keypad_model (
  input wire logic clk_in,
  input wire logic [15:0] keys_in,
  input wire logic [3:0] lone_row_in,
  input wire logic [3:0] row_pd_en_in,
  input wire logic [3:0] col_pu_en_in,
  output logic [3:0] row_out,
  output logic [3:0] col_out
);
  logic flip = 1'b0;
  logic [3:0] r;
  logic [3:0] c;
  always @(posedge clk_in) flip <= ~flip;
  always_comb begin
    r = lone_row_in;
    c = 4'h0;
    for (int i = 0; i < 16; i++) begin
      r[i/4] |= keys_in[i];
      c[i%4] |= keys_in[i];
    end
    // Unpulled lines toggle so a stale level cannot pass for idle
    row_out = r | (~row_pd_en_in & {4{flip}});
    col_out = c | (~col_pu_en_in & {4{flip}});
  end
endmodule : tdc_keypad_model
`default_nettype wire

// file: tb/tdc_control_tb.sv
// Bench for the disable and output control: table of key cases, then edge cases.
// Assumes the keypad model resolves the row and column lines.
`timescale 1ns/10ps
`default_nettype none
module tdc_control_tb;
  typedef struct {logic [15:0] k; logic [3:0] lr; logic d, p, m, lo, hi; logic [1:0] rs, cs;} tdc_case_s;
  tdc_case_s tbl [9] = '{
    '{16'h0001, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0},
    '{16'h4000, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 2'h2},
    '{16'h0090, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0},
    '{16'h0404, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 2'h2},
    '{16'h0021, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0},
    '{16'h0090, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0},
    '{16'h0000, 4'h4, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 2'h0},
    '{16'h0001, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0},
    '{16'h0001, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dis = 1'b0;
  logic permit = 1'b1;
  logic [15:0] keys = 16'h0;
  logic [3:0] lone_row = 4'h0;
  logic [3:0] row, col, rpd, cpu;
  logic dpd, osc, refh, tact, mute, ld, ld_oe_n, ref_prev;
  tdc_pkg::tdc_tone_s sel;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  tdc_keypad_model u_pad (.clk_in(clk), .keys_in(keys), .lone_row_in(lone_row),
    .row_pd_en_in(rpd), .col_pu_en_in(cpu), .row_out(row), .col_out(col));
  tdc_control u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .DEVICE_DISABLE_IN(dis),
    .SINGLE_TONE_PERMIT_IN(permit), .ROW_IN(row), .COL_IN(col), .ROW_PULLDOWN_EN_OUT(rpd),
    .COL_PULLUP_EN_OUT(cpu), .DISABLE_PULLDOWN_EN_OUT(dpd), .OSC_RUN_OUT(osc),
    .REF_HALF_OUT(refh), .TONE_ACTIVE_OUT(tact), .TONE_SEL_OUT(sel), .MUTE_OUT(mute),
    .LINE_DRIVE_OUT(ld), .LINE_DRIVE_OE_N_OUT(ld_oe_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // Whole run needs some 73 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    chk({2'h0, mute, ld_oe_n, osc, tact, ld, dpd}, 8'h03);
    chk({rpd, cpu}, 8'hff);
    rst = 1'b0;
    foreach (tbl[i]) begin
      keys = tbl[i].k;
      lone_row = tbl[i].lr;
      dis = tbl[i].d;
      permit = tbl[i].p;
      repeat (3) @(negedge clk);
      chk({5'h0, mute, ld_oe_n, tact}, {5'h0, tbl[i].m, tbl[i].m, tbl[i].lo | tbl[i].hi});
      if (!tbl[i].d) chk({6'h0, sel.low_en, sel.high_en}, {6'h0, tbl[i].lo, tbl[i].hi});
      if (tbl[i].lo) chk({6'h0, sel.row_sel}, {6'h0, tbl[i].rs});
      if (tbl[i].hi) chk({6'h0, sel.col_sel}, {6'h0, tbl[i].cs});
      chk({rpd, cpu}, {8{~tbl[i].d}});
      chk({7'h0, osc}, {7'h0, ~tbl[i].d});
      keys = 16'h0;
      lone_row = 4'h0;
      dis = 1'b0;
      permit = 1'b1;
      repeat (3) @(negedge clk);
      chk({6'h0, mute, osc}, 8'h00);
    end
    keys = 16'h0001;
    repeat (3) @(negedge clk);
    ref_prev = refh;
    @(negedge clk);
    chk({7'h0, refh}, {7'h0, ~ref_prev});
    dis = 1'b1;
    #1;
    chk({rpd, cpu}, 8'h00);
    chk({6'h0, osc, tact}, 8'h00);
    @(negedge clk);
    chk({6'h0, mute, ld_oe_n}, 8'h00);
    keys = 16'h0;
    dis = 1'b0;
    repeat (2) @(negedge clk);
    chk({5'h0, mute, osc, tact}, 8'h00);
    keys = 16'h0001;
    repeat (3) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk({6'h0, mute, osc}, 8'h00);
    wrap_up();
  end
endmodule : tdc_control_tb
`default_nettype wire
